/* rcc_checker_sva.sv */
// concurrent checks on the reference clock configuration block
// sees only the top ports; bound into every instance below
`default_nettype none
module rcc_checker
    import rcc_pkg::*;
(
    input wire logic pclk, presetn, psel, penable, pwrite, pslverr, pll_lock, // clock, reset, apb, lock
    input wire logic crystal_select_pin, pll_lock_raw, crystal_osc_enable, system_clock_from_pll, // pins
    input wire logic phase_detector_reset, buffered_reference_output_en, // controls
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [3:0] pstrb, // strobes
    input wire logic [6:0] pll_multiplier, // factor
    input wire logic [2:0] oscillator_band_select, pump_current_setting, // band, pump
    input wire logic [1:0] output_drive_strength // drive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cfg_wr;
    assign cfg_wr = psel && penable && pwrite && paddr == rcc_addr_config;
    AST_SEL: assert property (cfg_wr && pstrb[1] && !pwdata[rcc_pll_en_bit] |=> ##1 !system_clock_from_pll)
        else $error("direct path not selected");
    AST_BYPASS: assert property (system_clock_from_pll |-> oscillator_band_select <= rcc_band_last)
        else $error("pll path with bypass band");
    AST_BAND: assert property (cfg_wr && pstrb[3] |=> ##1 oscillator_band_select == $past(pwdata[26:24], 2))
        else $error("band not taken");
    AST_PUMP: assert property (cfg_wr && pstrb[2] |=> ##1 pump_current_setting == $past(pwdata[21:19], 2))
        else $error("pump not taken");
    AST_REFOUT: assert property (buffered_reference_output_en |-> system_clock_from_pll && output_drive_strength != 2'h0)
        else $error("reference output without pll");
    AST_DRVOFF: assert property (!system_clock_from_pll |-> output_drive_strength == rcc_drive_off)
        else $error("drive on while direct");
    AST_XTAL: assert property (1'b1 |=> crystal_osc_enable == $past(crystal_select_pin))
        else $error("crystal enable not following pin");
    AST_MULT: assert property ($past(presetn) |-> pll_multiplier >= rcc_mult_min)
        else $error("multiplier below range");
    AST_LOCK_SET: assert property (system_clock_from_pll && pll_lock_raw && !phase_detector_reset |=> pll_lock)
        else $error("lock not set");
    AST_LOCK_CLR: assert property (phase_detector_reset |=> !pll_lock)
        else $error("lock not cleared");
    AST_LOCK_HOLD: assert property (pll_lock && !phase_detector_reset |=> pll_lock)
        else $error("lock not latched");
    AST_ERR: assert property (psel && penable && paddr > rcc_addr_status |-> pslverr)
        else $error("unmapped access without error");
endmodule
bind rcc_reference_clock_config rcc_checker u_rcc_checker (.*);
`default_nettype wire

/* rcc_pkg.sv */
// constants, field layout and carrier types for the reference clock configuration block
// assumes a 32-bit apb slave clocked by pclk at 100 mhz; analog clock path lives outside
// Function
// - one pll enable bit picks pll multiplier path or direct reference path
// - with pll enabled a buffered copy of the reference leaves the output pin
// - two-bit drive field: 00 tristate, 01 low, 10 medium, 11 high current
// - crystal select pin high enables the internal crystal oscillator as source
// - pll multiplier accepts integer factors from 12 to 127
// - three-bit band field: 000..101 bands zero to five, 110 and 111 bypass pll
// - three-bit pump field sets charge pump current, 212 uA up to 387 uA
// - lock output latches high on lock, cleared while phase detector reset is set
`default_nettype none

package rcc_pkg;

    localparam logic [11:0] rcc_addr_config = 12'h000;
    localparam logic [11:0] rcc_addr_status = 12'h004;

    localparam int rcc_drive_lsb = 28;
    localparam int rcc_band_lsb = 24;
    localparam int rcc_pump_lsb = 19;
    localparam int rcc_div_bit = 15;
    localparam int rcc_pdreset_bit = 10;
    localparam int rcc_pll_en_bit = 8;
    localparam int rcc_mult_lsb = 1;

    // multiplier field is bits [7:1], so the whole low byte except bit 0 must be writable
    localparam logic [31:0] rcc_config_writable = 32'h373f_85fe;
    localparam logic [31:0] rcc_config_reset = 32'h1f3f_4000;

    localparam logic [6:0] rcc_mult_min = 7'h0c;
    localparam logic [6:0] rcc_mult_max = 7'h7f;
    localparam logic [2:0] rcc_band_last = 3'h5;

    localparam logic [1:0] rcc_drive_off = 2'h0;

    typedef enum logic [1:0] {
        rcc_drive_tristate_type_off,
        rcc_drive_low,
        rcc_drive_medium,
        rcc_drive_high
    } rcc_drive_type;

    typedef struct packed {
        logic [1:0] drive;
        logic [2:0] band;
        logic [2:0] pump;
        logic div_en;
        logic pdreset;
        logic pll_en;
        logic [6:0] mult;
    } rcc_cfg_type;

    typedef struct packed {
        logic use_pll;
        logic ref_out_en;
        logic [1:0] ref_out_drive;
        logic [2:0] band;
        logic [2:0] pump;
        logic [6:0] mult;
        logic div_en;
        logic pdreset;
    } rcc_ctrl_type;

endpackage

`default_nettype wire

/* rcc_ref_source.sv */
// model of the reference source and analog pll seen from the block
// raw lock rises seven edges after the pll path is chosen, drops on the next edge otherwise
`default_nettype none
module rcc_ref_source (
    input wire logic pclk, // bench clock
    input wire logic use_pll, // pll path active
    input wire logic want_xtal, // bench asks for a crystal
    output logic crystal_select_pin, // strap level
    output logic pll_lock_raw // raw lock level
);
    logic [2:0] settle;
    assign crystal_select_pin = want_xtal;
    always_ff @(posedge pclk) begin
        if (!use_pll) settle <= 3'h0;
        else if (settle != 3'h7) settle <= settle + 3'h1;
    end
    assign pll_lock_raw = settle == 3'h7;
endmodule
`default_nettype wire

/* rcc_reference_clock_config.sv */
// reference clock front end configuration: apb register, path select, band, pump, drive, lock latch
// assumes the analog pll reports a raw lock level synchronous to pclk and takes static controls
//
// Chosen here: the placing of the registers and the APB slave port.
`default_nettype none

module rcc_reference_clock_config
    import rcc_pkg::*;
(
    input wire logic pclk, // apb clock, 100 mhz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready, always high
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error on unmapped address
    input wire logic crystal_select_pin, // high selects crystal oscillator
    input wire logic pll_lock_raw, // raw lock level from the pll
    output logic crystal_osc_enable, // enables the internal crystal oscillator
    output logic system_clock_from_pll, // high: system_sample_clock from pll path
    output logic input_divider_enable, // enables the reference input divider
    output logic [6:0] pll_multiplier, // pll integer multiplication factor
    output logic [2:0] oscillator_band_select, // oscillator band code
    output logic [2:0] pump_current_setting, // charge pump current code
    output logic phase_detector_reset, // holds the phase detector in reset
    output logic buffered_reference_output_en, // output buffer enable for reference copy
    output logic [1:0] output_drive_strength, // reference output drive code
    output logic pll_lock // latched lock indication
);

    logic [31:0] config_word;
    logic crystal_select;
    logic lock_latched;
    logic mult_bad;
    rcc_cfg_type cfg;
    rcc_ctrl_type next_ctrl;
    rcc_ctrl_type ctrl;

    logic setup_write;
    logic access_done;
    logic hit_config;
    logic hit_status;

    // field extraction used for both the control path and the status readback
    function automatic rcc_cfg_type unpack_cfg(input logic [31:0] w);
        rcc_cfg_type c;
        c.drive = w[rcc_drive_lsb +: 2];
        c.band = w[rcc_band_lsb +: 3];
        c.pump = w[rcc_pump_lsb +: 3];
        c.div_en = w[rcc_div_bit];
        c.pdreset = w[rcc_pdreset_bit];
        c.pll_en = w[rcc_pll_en_bit];
        c.mult = w[rcc_mult_lsb +: 7];
        return c;
    endfunction

    // band codes above the last band mean bypass
    function automatic logic band_is_bypass(input logic [2:0] b);
        return b > rcc_band_last;
    endfunction

    function automatic logic mult_in_range(input logic [6:0] m);
        return (m >= rcc_mult_min) && (m <= rcc_mult_max);
    endfunction

    function automatic logic [31:0] merge_strobes(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign cfg = unpack_cfg(config_word);

    // apb decode; zero wait states keep the master simple
    assign access_done = psel && penable;
    assign hit_config = (paddr == rcc_addr_config);
    assign hit_status = (paddr == rcc_addr_status);
    assign setup_write = access_done && pwrite && hit_config;
    assign pready = 1'b1;
    assign pslverr = access_done && !(hit_config || hit_status);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_word <= rcc_config_reset;
        end else if (setup_write) begin
            config_word <= merge_strobes(config_word, pwdata, pstrb) & rcc_config_writable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_select <= 1'b0;
        end else begin
            crystal_select <= crystal_select_pin;
        end
    end

    // decoded control set
    always_comb begin
        next_ctrl = '0;
        next_ctrl.use_pll = cfg.pll_en && !band_is_bypass(cfg.band);
        next_ctrl.ref_out_en = next_ctrl.use_pll && (cfg.drive != rcc_drive_off);
        next_ctrl.ref_out_drive = next_ctrl.use_pll ? cfg.drive : rcc_drive_off;
        next_ctrl.band = cfg.band;
        next_ctrl.pump = cfg.pump;
        next_ctrl.mult = mult_in_range(cfg.mult) ? cfg.mult : rcc_mult_min;
        next_ctrl.div_en = cfg.div_en;
        next_ctrl.pdreset = cfg.pdreset;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // flags an out-of-range multiplier so software sees the substitution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_bad <= 1'b0;
        end else begin
            mult_bad <= !mult_in_range(cfg.mult);
        end
    end

    // lock latch
    // reset bit held wins over a lock report: the detector cannot lock while held anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_latched <= 1'b0;
        end else if (ctrl.pdreset) begin
            lock_latched <= 1'b0;
        end else if (ctrl.use_pll && pll_lock_raw) begin
            lock_latched <= 1'b1;
        end
    end

    // read data registered for the access phase of the same transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (hit_config) begin
                prdata <= config_word;
            end else if (hit_status) begin
                prdata <= {26'h0, mult_bad, ctrl.ref_out_en, ctrl.use_pll,
                           crystal_select, pll_lock_raw, lock_latched};
            end else begin
                prdata <= '0;
            end
        end
    end

    assign crystal_osc_enable = crystal_select;
    assign system_clock_from_pll = ctrl.use_pll;
    assign input_divider_enable = ctrl.div_en;
    assign pll_multiplier = ctrl.mult;
    assign oscillator_band_select = ctrl.band;
    assign pump_current_setting = ctrl.pump;
    assign phase_detector_reset = ctrl.pdreset;
    assign buffered_reference_output_en = ctrl.ref_out_en;
    assign output_drive_strength = ctrl.ref_out_drive;
    assign pll_lock = lock_latched;

endmodule

`default_nettype wire

/* tb_top.sv */
// self-checking bench: apb master, read scoreboard, pin checks
// assumes a zero-wait apb slave and the reference source model
`default_nettype none
module tb_top;
    import rcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, want_xtal = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, w;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, crystal_select_pin, pll_lock_raw, crystal_osc_enable, system_clock_from_pll;
    logic input_divider_enable, phase_detector_reset, buffered_reference_output_en, pll_lock;
    logic [6:0] pll_multiplier, m;
    logic [2:0] oscillator_band_select, pump_current_setting;
    logic [1:0] output_drive_strength;
    logic [32:0] expq[$];
    int num_errors = 0, total_checks = 0;
    rcc_reference_clock_config u_rcc_reference_clock_config (.*);
    rcc_ref_source u_rcc_ref_source (.pclk(pclk), .use_pll(system_clock_from_pll), .want_xtal(want_xtal),
        .crystal_select_pin(crystal_select_pin), .pll_lock_raw(pll_lock_raw));
    always #5 pclk = ~pclk;
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reads carry {pslverr, prdata}; expectation queued by the master
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() > 0) cmp({pslverr, prdata}, expq.pop_front());
            else num_errors++;
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        if (!wr) expq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            num_errors++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // controls land one edge after the store; sample them settled
    task automatic settle();
        repeat (12) @(posedge pclk);
        #1;
    endtask
    initial begin
        void'($urandom(32'h222b));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, rcc_addr_config, 0, {1'b0, rcc_config_reset});
        apb(1, rcc_addr_config, 32'hffff_ffff, 0);
        apb(0, rcc_addr_config, 0, {1'b0, rcc_config_writable});
        settle();
        cmp(system_clock_from_pll, 0);
        cmp(input_divider_enable, 1);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            m = 7'($urandom_range(127, 12));
            w = 32'((i % 4) << rcc_drive_lsb | i << rcc_band_lsb | (7 - i) << rcc_pump_lsb | 1 << rcc_pll_en_bit);
            apb(1, rcc_addr_config, w | 32'(m) << rcc_mult_lsb, 0);
            settle();
            cmp(system_clock_from_pll, i < 6);
            cmp(output_drive_strength, i < 6 ? i % 4 : 0);
            cmp(buffered_reference_output_en, i < 6 && i % 4 != 0);
            cmp(pump_current_setting, 7 - i);
            cmp(oscillator_band_select, i);
            cmp(pll_multiplier, m);
        end
        $display("decode test done");
        w = 32'(1 << rcc_pll_en_bit | 20 << rcc_mult_lsb);
        apb(1, rcc_addr_config, w, 0);
        settle();
        cmp(pll_lock, 1);
        apb(0, rcc_addr_status, 0, 33'h0_0000_000b);
        apb(1, rcc_addr_config, w | 32'(1 << rcc_pdreset_bit), 0);
        settle();
        cmp({phase_detector_reset, pll_lock}, 2'h2);
        apb(1, rcc_addr_config, w, 0);
        settle();
        cmp(pll_lock, 1);
        apb(1, rcc_addr_config, 32'(5 << rcc_mult_lsb), 0);
        settle();
        cmp({system_clock_from_pll, pll_multiplier}, {1'b0, rcc_mult_min});
        apb(0, rcc_addr_status, 0, 33'h0_0000_0021);
        $display("lock test done");
        @(posedge pclk);
        want_xtal <= 1'b1;
        settle();
        cmp(crystal_osc_enable, 1);
        apb(1, rcc_addr_status, 32'hffff_ffff, 0);
        apb(0, rcc_addr_status, 0, 33'h0_0000_0025);
        apb(0, 12'h008, 0, 33'h1_0000_0000);
        $display("crystal and error test done");
        give_verdict();
    end
endmodule
`default_nettype wire
